/* File: hdl/mlf_filter.sv */
// ipv6 mld and neighbor solicitation multicast classifier
// assumes frames arrive one byte per valid cycle, on mclk, from mac byte 0
// Summary of operation
// - enable bit 4 forwards mld, else discard
// - category needs every criterion matched together
// - mld needs dest mac 33:33:00:00:00:01
// - both categories need ethertype 0x86dd
// - both categories need next header 58
// - mld needs icmpv6 type 130-132
// - enable bit 5 forwards solicitation, else discard
// - solicitation checks only first three mac bytes
// - solicitation needs icmpv6 type 135
// - each category optional; omitted enable does nothing
// - forward matching solicitation while enabled, unless its sof lands one cycle after the previous frame's eof
`timescale 1ns/100ps
`include "mlf_regs.svh"
module mlf_filter
   import mlf_pkg::*;
#(
   parameter bit HAS_MLD = 1'b1,
   parameter bit HAS_NS  = 1'b1
) (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic [`MLF_EN_W-1:0]  filter_en,
   input  wire logic                  rx_sof,
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_data,
   input  wire logic                  rx_eof,
   output logic                       fwd_valid,
   output logic                       fwd_mld,
   output logic                       fwd_nsol
);
   mlf_state_e              state;
   mlf_state_e              next_state;
   logic [`MLF_CNT_W-1:0]   ofs;
   logic [`MLF_CNT_W-1:0]   next_ofs;
   logic [47:0]             dmac;
   logic [47:0]             next_dmac;
   logic                    next_fwd_valid;
   logic                    next_fwd_mld;
   logic                    next_fwd_nsol;
   logic [7:0]              et_hi;
   logic [7:0]              et_lo;
   logic [7:0]              nh;
   logic [7:0]              ictype;
   logic                    ipv6_icmp;
   logic                    is_mld;
   logic                    is_nsol;
   logic                    clr;
   logic                    byte_ok;

   assign clr     = rx_sof && rx_valid;
   assign byte_ok = rx_valid && state == MLF_HDR;

   // header byte catchers: two for the ethertype, one each for next header and icmpv6 type
   mlf_byte_cap #(.OFS(`MLF_CNT_W'(`MLF_OFS_ETYPE_HI))) u_et_hi (
      .mclk(mclk), .srst(srst), .clr(clr), .in_valid(byte_ok),
      .in_ofs(ofs), .in_data(rx_data), .cap(et_hi));
   mlf_byte_cap #(.OFS(`MLF_CNT_W'(`MLF_OFS_ETYPE_LO))) u_et_lo (
      .mclk(mclk), .srst(srst), .clr(clr), .in_valid(byte_ok),
      .in_ofs(ofs), .in_data(rx_data), .cap(et_lo));
   mlf_byte_cap #(.OFS(`MLF_CNT_W'(`MLF_OFS_NEXT_HDR))) u_nh (
      .mclk(mclk), .srst(srst), .clr(clr), .in_valid(byte_ok),
      .in_ofs(ofs), .in_data(rx_data), .cap(nh));
   mlf_byte_cap #(.OFS(`MLF_CNT_W'(`MLF_OFS_ICMP_TYPE))) u_ictype (
      .mclk(mclk), .srst(srst), .clr(clr), .in_valid(byte_ok),
      .in_ofs(ofs), .in_data(rx_data), .cap(ictype));

   // classification from this frame's bytes only
   always_comb begin
      ipv6_icmp = ({et_hi, et_lo} == `MLF_ETYPE_IPV6)
               && (nh == `MLF_NH_ICMPV6);
      is_mld    = HAS_MLD && ipv6_icmp
               && (dmac == `MLF_MAC_ALLNODES)
               && (ictype == `MLF_ICMP_MLQ || ictype == `MLF_ICMP_MLR
                   || ictype == `MLF_ICMP_MLD_DONE);
      // low three mac bytes are don't-care, so every solicited node hits
      is_nsol   = HAS_NS && ipv6_icmp
               && (dmac[47:24] == `MLF_MAC_SOLNODE)
               && (ictype == `MLF_ICMP_NSOL);
   end

   // byte walk: mac capture, offset count, one verdict per frame
   always_comb begin
      next_state     = state;
      next_ofs       = ofs;
      next_dmac      = dmac;
      next_fwd_valid = 1'b0;
      next_fwd_mld   = fwd_mld;
      next_fwd_nsol  = fwd_nsol;
      case (state)
         MLF_IDLE: begin
            if (clr) begin
               next_state = MLF_HDR;
               next_ofs   = `MLF_CNT_W'(1);
               next_dmac  = {rx_data, 40'h00_0000_0000};
            end
         end
         MLF_HDR: begin
            if (clr) begin
               next_ofs  = `MLF_CNT_W'(1);
               next_dmac = {rx_data, 40'h00_0000_0000};
            end else if (rx_valid) begin
               if (ofs < `MLF_CNT_W'(6)) begin
                  next_dmac[8'(47 - 8*ofs) -: 8] = rx_data;
               end
               if (ofs != `MLF_CNT_MAX) begin
                  next_ofs = ofs + `MLF_CNT_W'(1);
               end
               if (rx_eof) begin
                  next_state = MLF_DONE;
               end
            end
         end
         MLF_DONE: begin
            // verdict issued once, then wait for next frame
            next_fwd_valid = 1'b1;
            next_fwd_mld   = is_mld && filter_en[`MLF_EN_MLD_BIT];
            next_fwd_nsol  = is_nsol && filter_en[`MLF_EN_NS_BIT];
            next_state     = MLF_IDLE;
         end
         default: begin
            next_state = MLF_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state     <= MLF_IDLE;
         ofs       <= '0;
         dmac      <= '0;
         fwd_valid <= 1'b0;
         fwd_mld   <= 1'b0;
         fwd_nsol  <= 1'b0;
      end else begin
         state     <= next_state;
         ofs       <= next_ofs;
         dmac      <= next_dmac;
         fwd_valid <= next_fwd_valid;
         fwd_mld   <= next_fwd_mld;
         fwd_nsol  <= next_fwd_nsol;
      end
   end
endmodule

/* File: hdl/mlf_regs.svh */
// constants for the ipv6 mld / neighbor solicitation receive classifier
// assumes byte-wide frame stream starting at the destination mac address
`ifndef MLF_REGS_SVH
`define MLF_REGS_SVH
`define MLF_EN_MLD_BIT     4
`define MLF_EN_NS_BIT      5
`define MLF_EN_W           8
`define MLF_MAC_ALLNODES   48'h3333_0000_0001
`define MLF_MAC_SOLNODE    24'h3333ff
`define MLF_ETYPE_IPV6     16'h86dd
`define MLF_NH_ICMPV6      8'h3a
`define MLF_ICMP_MLQ       8'h82
`define MLF_ICMP_MLR       8'h83
`define MLF_ICMP_MLD_DONE  8'h84
`define MLF_ICMP_NSOL      8'h87
`define MLF_OFS_ETYPE_HI   12
`define MLF_OFS_ETYPE_LO   13
`define MLF_OFS_NEXT_HDR   20
`define MLF_OFS_ICMP_TYPE  54
`define MLF_CNT_W          6
`define MLF_CNT_MAX        6'h3f
`endif

/* File: hdl/mlf_pkg.sv */
// types shared by the classifier files
// assumes mlf_regs.svh holds all numeric constants
package mlf_pkg;
   typedef enum logic [2:0] {
      MLF_IDLE = 3'b001,
      MLF_HDR  = 3'b010,
      MLF_DONE = 3'b100
   } mlf_state_e;
endpackage

/* File: hdl/mlf_byte_cap.sv */
// one header byte catcher: latches the stream byte at a fixed offset
// assumes offset counter and valid come from the same clock
`timescale 1ns/100ps
`include "mlf_regs.svh"
module mlf_byte_cap
   import mlf_pkg::*;
#(
   parameter logic [`MLF_CNT_W-1:0] OFS = '0
) (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic                  clr,
   input  wire logic                  in_valid,
   input  wire logic [`MLF_CNT_W-1:0] in_ofs,
   input  wire logic [7:0]            in_data,
   output logic      [7:0]            cap
);
   logic [7:0] next_cap;

   // clear at frame start so a short frame never reuses old bytes
   always_comb begin
      next_cap = cap;
      if (clr) begin
         next_cap = 8'h00;
      end else if (in_valid && in_ofs == OFS) begin
         next_cap = in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cap <= 8'h00;
      end else begin
         cap <= next_cap;
      end
   end
endmodule

/* File: sim/mlf_mc_model.sv */
// management controller model: counts the copies it is handed
// assumes verdicts from mlf_filter on the same mclk
`timescale 1ns/100ps
module mlf_mc_model (
   input  wire logic mclk,
   input  wire logic fwd_valid,
   input  wire logic fwd_mld,
   input  wire logic fwd_nsol,
   output int        n_rx
);
   // no per-address filter is programmed, so the broad filter is used
   initial n_rx = 0;
   // a doubled copy of one frame shows up as an extra count
   always @(posedge mclk) begin
      if (fwd_valid && (fwd_mld || fwd_nsol)) n_rx <= n_rx + 1;
   end
endmodule

/* File: sim/mlf_filter_assertions.sv */
// port checker for the classifier
// assumes bound to mlf_filter and fed only whole sof..eof frames
`timescale 1ns/100ps
`include "mlf_regs.svh"
module mlf_filter_assertions (
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic [7:0] filter_en,
   input wire logic       rx_sof,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_eof,
   input wire logic       fwd_valid,
   input wire logic       fwd_mld,
   input wire logic       fwd_nsol
);
   logic [5:0] cnt;
   logic [7:0] typ;
   // own offset count, so the type byte is seen apart from the design
   always_ff @(posedge mclk) begin
      if (rx_valid) cnt <= rx_sof ? 6'h01 : cnt + 6'h01;
      if (rx_valid && (rx_sof ? 6'h00 : cnt) == 6'h36) typ <= rx_data;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_end; rx_valid && rx_eof; endsequence
   property p_lat; s_end |-> ##2 fwd_valid; endproperty
   a_lat: assert property (p_lat) else $error("verdict not two cycles after eof");
   property p_once; fwd_valid |=> !fwd_valid; endproperty
   a_once: assert property (p_once) else $error("verdict longer than one cycle");
   property p_cause; fwd_valid |-> $past(rx_valid && rx_eof, 2); endproperty
   a_cause: assert property (p_cause) else $error("verdict without frame end");
   property p_hold; !fwd_valid |-> $stable({fwd_mld, fwd_nsol}); endproperty
   a_hold: assert property (p_hold) else $error("flags moved between verdicts");
   // enables are taken one cycle before the verdict shows
   property p_mld_en; fwd_valid && !$past(filter_en[4]) |-> !fwd_mld; endproperty
   a_mld_en: assert property (p_mld_en) else $error("mld kept while off");
   property p_ns_en; fwd_valid && !$past(filter_en[5]) |-> !fwd_nsol; endproperty
   a_ns_en: assert property (p_ns_en) else $error("solicitation kept while off");
   property p_mld_ty; fwd_valid && fwd_mld |-> typ inside {8'h82, 8'h83, 8'h84}; endproperty
   a_mld_ty: assert property (p_mld_ty) else $error("mld with wrong type");
   property p_ns_ty; fwd_valid && fwd_nsol |-> typ == 8'h87; endproperty
   a_ns_ty: assert property (p_ns_ty) else $error("solicitation with wrong type");
endmodule

/* File: sim/mlf_filter_tb.sv */
// random frames through the classifier, checked per verdict
// assumes mlf_filter with both categories present
`timescale 1ns/100ps
`include "mlf_regs.svh"
module mlf_filter_tb;
   logic        mclk = 0, srst = 1, rx_sof = 0, rx_valid = 0, rx_eof = 0;
   logic [7:0]  filter_en = 0, rx_data = 0, nh, ty, tys [8];
   logic        fwd_valid, fwd_mld, fwd_nsol;
   logic [47:0] mac;
   logic [15:0] et;
   logic [31:0] r;
   int          n_fail = 0, total_checks = 0, seed = 5361, n_exp = 0, n_rx, cyc = 0, k, i;
   always #20 mclk = ~mclk;
   mlf_filter dut (.mclk, .srst, .filter_en, .rx_sof, .rx_valid, .rx_data, .rx_eof,
                   .fwd_valid, .fwd_mld, .fwd_nsol);
   mlf_mc_model u_mc (.mclk, .fwd_valid, .fwd_mld, .fwd_nsol, .n_rx);
   task summarize;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // expected verdict, worked out from the frame fields
   function automatic logic [1:0] fw(input logic [7:0] f);
      logic b;
      b = et == 16'h86dd && nh == 8'h3a;
      return {f[4] && b && mac == 48'h3333_0000_0001 && ty inside {8'h82, 8'h83, 8'h84},
              f[5] && b && mac[47:24] == 24'h3333ff && ty == 8'h87};
   endfunction
   task chk(input logic [1:0] e);
      total_checks++;
      if (fwd_valid !== 1'b1 || {fwd_mld, fwd_nsol} !== e) begin
         n_fail++;
         $display("ERROR %0t verdict %b%b", $time, fwd_mld, fwd_nsol);
      end
   endtask
   // 60-byte untagged frame; returns in the cycle the one-cycle verdict stands
   task send;
      for (i = 0; i < 60; i++) begin
         @(negedge mclk);
         rx_valid = 1;
         rx_sof = (i == 0);
         rx_eof = (i == 59);
         rx_data = i < 6 ? mac[8*(5-i) +: 8] : i == 12 ? et[15:8] : i == 13 ? et[7:0] :
                   i == 20 ? nh : i == 54 ? ty : 8'($random(seed));
      end
      @(negedge mclk);
      rx_valid = 0;
      rx_eof = 0;
      @(negedge mclk);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         summarize;
      end
   end
   initial begin
      tys = '{8'h82, 8'h83, 8'h84, 8'h87, 8'h86, 8'h85, 8'h88, 8'h81};
      repeat (4) @(negedge mclk);
      srst = 0;
      // first four: mld mac and type with wrong ethertype and next header, under each enable pair, then random
      for (k = 0; k < 300; k++) begin
         filter_en = k < 4 ? 8'(k << 4) : 8'($random(seed));
         r = k < 4 ? 32'h0 : $random(seed);
         mac = r[1:0] == 0 ? 48'h3333_0000_0001 : r[1:0] == 1 ? {24'h3333ff, r[31:8]} :
               r[1:0] == 2 ? 48'h3333_fe00_0001 : 48'h3333_0000_0101;
         et = r[3:2] != 0 ? 16'h86dd : 16'h86dc;
         nh = r[5:4] != 0 ? 8'h3a : 8'h3b;
         ty = tys[r[8:6]];
         send;
         chk(fw(filter_en));
         if (|fw(filter_en)) n_exp++;
      end
      // let the last verdict reach the controller model first
      @(negedge mclk);
      total_checks++;
      if (n_rx != n_exp) begin
         n_fail++;
         $display("ERROR %0t copies %0d", $time, n_rx);
      end
      summarize;
   end
endmodule
bind mlf_filter mlf_filter_assertions u_chk (.mclk, .srst, .filter_en, .rx_sof, .rx_valid,
   .rx_data, .rx_eof, .fwd_valid, .fwd_mld, .fwd_nsol);
